/* core/code_flash_ctrl.v */
`timescale 1ns/1ps
`default_nettype none
`include "code_flash_map.vh"
module code_flash_ctrl #(
   parameter CLK_MHZ      = 20,
   parameter ADDR_W       = 21,
   parameter BLK_W        = 15,
   parameter PROG_CYCLES  = 64,
   parameter ERASE_CYCLES = 256,
   // id words are arbitrary values
   parameter [31:0] UID0  = 32'h1111_1111,
   parameter [31:0] UID1  = 32'h2222_2222,
   parameter [31:0] UID2  = 32'h3333_3333,
   parameter [31:0] UID3  = 32'h4444_4444
) (
   // clock and reset
   input  wire              clk_i,
   input  wire              rst_i,
   // wishbone slave
   input  wire              wb_cyc_i,
   input  wire              wb_stb_i,
   input  wire              wb_we_i,
   input  wire [7:0]        wb_adr_i,
   input  wire [3:0]        wb_sel_i,
   input  wire [31:0]       wb_dat_i,
   output reg  [31:0]       wb_dat_o,
   output reg               wb_ack_o,
   // processor read port
   input  wire              rd_req_i,
   input  wire [ADDR_W-1:0] rd_addr_i,
   output reg               rd_ack_o,
   output reg               rd_err_o,
   output reg  [31:0]       rd_data_o,
   // flash array side
   output wire              fl_rd_o,
   output reg  [ADDR_W-5:0] fl_raddr_o,
   input  wire [127:0]      fl_line_i,
   output reg               fl_wr_o,
   output reg  [ADDR_W-3:0] fl_waddr_o,
   output reg  [31:0]       fl_wdata_o,
   output reg               fl_erase_o,
   output reg  [5:0]        fl_eblk_o,
   // interrupt
   output wire              irq_o
);
   // ==========================================
   // constants
   localparam [1:0] MISS_CYC = (CLK_MHZ <= `CF_MHZ_1CYC) ? 2'd1 :
                               (CLK_MHZ <= `CF_MHZ_2CYC) ? 2'd2 : 2'd3;
   // busy countdown start values, cut to the timer width where loaded
   localparam [31:0] ERASE_LOAD = ERASE_CYCLES - 1;
   localparam [31:0] PROG_LOAD  = PROG_CYCLES - 1;
   localparam TAG_W = ADDR_W - 5;
   localparam NL    = `CF_WAYS * `CF_SETS;
   localparam [1:0] R_IDLE = 2'd0, R_MISS = 2'd1;
   localparam [1:0] P_IDLE = 2'd0, P_COLL = 2'd1, P_BUSY = 2'd2;
   // ==========================================
   // registers
   reg  [3:0]        ctrl_reg;       // pe_enable_field, dual, guard
   reg               cache_en_reg;   // cache_enable_reg
   reg               startup_reg;    // startup_area_select_reg
   reg  [1:0]        status_reg;     // sticky events
   reg  [1:0]        mask_reg;       // interrupt enables
   reg  [ADDR_W-1:0] pe_addr_reg;    // program/erase target
   reg  [63:0]       blank_reg;      // erased-block map
   reg  [1:0]        pstate_reg;     // sequencer state
   reg               prog_reg;       // busy op is a program
   reg               susp_reg;       // suspended
   reg               blank_res_reg;  // last blank check result
   reg  [4:0]        wcnt_reg;       // program word count
   reg  [15:0]       timer_reg;      // busy countdown
   reg  [1:0]        rstate_reg;     // read state
   reg  [1:0]        lat_reg;        // miss wait count
   reg  [ADDR_W-1:0] raddr_reg;      // latched read address
   reg  [127:0]      line_mem [0:NL-1];
   reg  [TAG_W-1:0]  tag_mem  [0:NL-1];
   reg  [2:0]        age_mem  [0:NL-1];
   reg  [NL-1:0]     valid_reg;
   // ==========================================
   // bus decode
   wire       acc   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire       wr    = acc & wb_we_i;
   wire [5:0] widx  = wb_adr_i[7:2];
   wire       cmd_w = wr & (widx == `CF_CMD_AREA);
   wire [7:0] cmd   = wb_dat_i[7:0];
   wire       pe_ok = (ctrl_reg[1:0] == `CF_PE_ENABLED);
   wire       dual  = ctrl_reg[`CF_DUAL_BIT];
   wire       guard = ctrl_reg[`CF_GUARD_BIT];
   // ==========================================
   // address remap and block checks
   wire [ADDR_W-1:0] req_a = (rstate_reg == R_IDLE) ? rd_addr_i : raddr_reg;
   wire [5:0]        blk0  = req_a[BLK_W+5:BLK_W];
   // swap blocks 0 and 1 when the alternate startup block is chosen
   wire [5:0]        blk   = (startup_reg && blk0[5:1] == 5'd0) ?
                             {blk0[5:1], ~blk0[0]} : blk0;
   // the block field is the top of the address
   wire [ADDR_W-1:0] eff_a = {blk, req_a[BLK_W-1:0]};
   wire trusted = guard & ((blk == `CF_BLK_GUARD0) | (blk == `CF_BLK_GUARD1) |
                  (dual & ((blk == `CF_BLK_GUARD2) | (blk == `CF_BLK_GUARD3))));
   wire set_i   = eff_a[4];
   wire [TAG_W-1:0] tag = eff_a[ADDR_W-1:5];
   // ==========================================
   // cache lookup and victim choice
   reg       hit;
   reg [2:0] hway;
   reg [2:0] vway;
   integer   i;
   always @* begin
      hit  = 1'b0;
      hway = 3'd0;
      vway = 3'd0;
      for (i = 0; i < `CF_WAYS; i = i + 1) begin
         if (valid_reg[set_i*`CF_WAYS+i] && tag_mem[set_i*`CF_WAYS+i] == tag) begin
            hit  = 1'b1;
            hway = i[2:0];
         end
         if (age_mem[set_i*`CF_WAYS+i] == 3'd7) begin
            vway = i[2:0];
         end
      end
   end
   wire [3:0]   hidx  = {set_i, hway};
   wire [3:0]   vidx  = {set_i, vway};
   wire [127:0] hline = line_mem[hidx];
   wire [31:0]  hword = hline[eff_a[3:2]*32 +: 32];
   wire [31:0]  mword = fl_line_i[eff_a[3:2]*32 +: 32];
   wire         take  = (rstate_reg == R_IDLE) & rd_req_i & ~rd_ack_o;
   wire         r_hit = take & ~trusted & ~blank_reg[blk] & cache_en_reg & hit;
   wire         r_fill = (rstate_reg == R_MISS) & (lat_reg == 2'd0) &
                         cache_en_reg;
   wire         viol_rd = take & trusted;
   assign fl_rd_o = (rstate_reg == R_MISS);
   // ==========================================
   // read path
   always @(posedge clk_i) begin
      if (rst_i) begin
         rstate_reg <= R_IDLE;
         lat_reg    <= 2'd0;
         raddr_reg  <= {ADDR_W{1'b0}};
         rd_ack_o   <= 1'b0;
         rd_err_o   <= 1'b0;
         rd_data_o  <= 32'h0000_0000;
         fl_raddr_o <= {(ADDR_W-4){1'b0}};
      end else begin
         rd_ack_o <= 1'b0;
         rd_err_o <= 1'b0;
         case (rstate_reg)
            R_IDLE: begin
               if (take) begin
                  raddr_reg <= rd_addr_i;
                  if (trusted) begin
                     // blocked read answers with error and zero data
                     rd_ack_o  <= 1'b1;
                     rd_err_o  <= 1'b1;
                     rd_data_o <= 32'h0000_0000;
                  end else if (blank_reg[blk]) begin
                     rd_ack_o  <= 1'b1;
                     rd_data_o <= 32'hffff_ffff;
                  end else if (r_hit) begin
                     rd_ack_o  <= 1'b1;
                     rd_data_o <= hword;
                  end else begin
                     // miss or cache off: fetch from array
                     rstate_reg <= R_MISS;
                     lat_reg    <= MISS_CYC - 2'd1;
                     fl_raddr_o <= eff_a[ADDR_W-1:4];
                  end
               end
            end
            R_MISS: begin
               if (lat_reg == 2'd0) begin
                  rd_ack_o   <= 1'b1;
                  rd_data_o  <= mword;
                  rstate_reg <= R_IDLE;
               end else begin
                  lat_reg <= lat_reg - 2'd1;
               end
            end
            default: begin
               rstate_reg <= R_IDLE;
            end
         endcase
      end
   end
   // ==========================================
   // cache fill, lru ages and invalidate
   wire       inv_w  = wr & (widx == `CF_CACHE_INV) & wb_sel_i[0] & wb_dat_i[0];
   wire [3:0] uidx   = r_hit ? hidx : vidx;
   wire [2:0] uage   = age_mem[uidx];
   integer    j;
   always @(posedge clk_i) begin
      if (rst_i) begin
         valid_reg <= {NL{1'b0}};
         for (j = 0; j < NL; j = j + 1) begin
            age_mem[j] <= j[2:0];
         end
      end else begin
         if (r_fill) begin
            line_mem[vidx]  <= fl_line_i;
            tag_mem[vidx]   <= tag;
            valid_reg[vidx] <= 1'b1;
         end
         if (r_hit || r_fill) begin
            // most recent way gets age 0, younger ones age by one
            for (j = 0; j < `CF_WAYS; j = j + 1) begin
               if (age_mem[set_i*`CF_WAYS+j] < uage) begin
                  age_mem[set_i*`CF_WAYS+j] <= age_mem[set_i*`CF_WAYS+j] + 3'd1;
               end
            end
            age_mem[uidx] <= 3'd0;
         end
         if (inv_w) begin
            valid_reg <= {NL{1'b0}};
         end
      end
   end
   // ==========================================
   // program/erase sequencer
   reg pe_done;
   reg viol_cmd;
   always @(posedge clk_i) begin
      if (rst_i) begin
         pstate_reg    <= P_IDLE;
         prog_reg      <= 1'b0;
         susp_reg      <= 1'b0;
         blank_res_reg <= 1'b0;
         wcnt_reg      <= 5'd0;
         timer_reg     <= 16'd0;
         blank_reg     <= 64'h0000_0000_0000_0000;
         fl_wr_o       <= 1'b0;
         fl_waddr_o    <= {(ADDR_W-2){1'b0}};
         fl_wdata_o    <= 32'h0000_0000;
         fl_erase_o    <= 1'b0;
         fl_eblk_o     <= 6'd0;
         pe_done       <= 1'b0;
         viol_cmd      <= 1'b0;
      end else begin
         fl_wr_o    <= 1'b0;
         fl_erase_o <= 1'b0;
         pe_done    <= 1'b0;
         viol_cmd   <= 1'b0;
         case (pstate_reg)
            P_IDLE: begin
               if (cmd_w && !pe_ok) begin
                  viol_cmd <= 1'b1;
               end else if (cmd_w && cmd == `CF_CMD_PROG) begin
                  pstate_reg <= P_COLL;
                  wcnt_reg   <= 5'd0;
               end else if (cmd_w && cmd == `CF_CMD_ERASE) begin
                  pstate_reg <= P_BUSY;
                  prog_reg   <= 1'b0;
                  timer_reg  <= ERASE_LOAD[15:0];
                  fl_erase_o <= 1'b1;
                  fl_eblk_o  <= pe_addr_reg[BLK_W+5:BLK_W];
               end else if (cmd_w && cmd == `CF_CMD_BLANK) begin
                  blank_res_reg <= blank_reg[pe_addr_reg[BLK_W+5:BLK_W]];
                  pe_done       <= 1'b1;
               end else if (cmd_w) begin
                  viol_cmd <= 1'b1;
               end
            end
            P_COLL: begin
               if (cmd_w) begin
                  // each data word goes straight to the array
                  fl_wr_o    <= 1'b1;
                  fl_waddr_o <= {pe_addr_reg[ADDR_W-1:7], wcnt_reg};
                  fl_wdata_o <= wb_dat_i;
                  wcnt_reg   <= wcnt_reg + 5'd1;
                  if (wcnt_reg == `CF_PROG_WORDS - 1) begin
                     pstate_reg <= P_BUSY;
                     prog_reg   <= 1'b1;
                     timer_reg  <= PROG_LOAD[15:0];
                  end
               end
            end
            P_BUSY: begin
               if (cmd_w && cmd == `CF_CMD_SUSPEND) begin
                  susp_reg <= 1'b1;
               end else if (cmd_w && cmd == `CF_CMD_RESUME) begin
                  susp_reg <= 1'b0;
               end else if (cmd_w) begin
                  viol_cmd <= 1'b1;
               end
               // reads keep running beside the busy countdown
               if (!susp_reg) begin
                  if (timer_reg == 16'd0) begin
                     pstate_reg <= P_IDLE;
                     pe_done    <= 1'b1;
                     blank_reg[pe_addr_reg[BLK_W+5:BLK_W]] <= ~prog_reg;
                  end else begin
                     timer_reg <= timer_reg - 16'd1;
                  end
               end
            end
            default: begin
               pstate_reg <= P_IDLE;
            end
         endcase
      end
   end
   // ==========================================
   // control registers and sticky status
   wire [1:0] events = {pe_done, viol_cmd | viol_rd};
   wire [1:0] w1c    = (wr && widx == `CF_IRQ_STATUS && wb_sel_i[0]) ?
                       wb_dat_i[1:0] : 2'b00;
   always @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_reg     <= `CF_CTRL_RST;
         cache_en_reg <= 1'b0;
         startup_reg  <= 1'b0;
         status_reg   <= 2'b00;
         mask_reg     <= 2'b00;
         pe_addr_reg  <= {ADDR_W{1'b0}};
      end else begin
         // a new event wins over a clear in the same cycle
         status_reg <= (status_reg & ~w1c) | events;
         if (wr && wb_sel_i[0]) begin
            case (widx)
               `CF_PE_CTRL:     ctrl_reg     <= wb_dat_i[3:0];
               `CF_CACHE_EN:    cache_en_reg <= wb_dat_i[0];
               `CF_STARTUP_SEL: startup_reg  <= wb_dat_i[0];
               `CF_IRQ_MASK:    mask_reg     <= wb_dat_i[1:0];
               default:         ;
            endcase
         end
         if (wr && widx == `CF_PE_ADDR && pstate_reg == P_IDLE) begin
            pe_addr_reg <= wb_dat_i[ADDR_W-1:0];
         end
      end
   end
   assign irq_o = |(status_reg & mask_reg);
   // ==========================================
   // bus read mux and ack
   reg [31:0] rdat;
   always @* begin
      case (widx)
         `CF_PE_CTRL:     rdat = {28'd0, ctrl_reg};
         `CF_CACHE_EN:    rdat = {31'd0, cache_en_reg};
         `CF_STARTUP_SEL: rdat = {31'd0, startup_reg};
         `CF_IRQ_STATUS:  rdat = {30'd0, status_reg};
         `CF_IRQ_MASK:    rdat = {30'd0, mask_reg};
         `CF_PE_STATE:    rdat = {28'd0, blank_res_reg, susp_reg, pstate_reg};
         `CF_PE_ADDR:     rdat = {{(32-ADDR_W){1'b0}}, pe_addr_reg};
         `CF_UID_BASE:    rdat = UID0;
         6'h09:           rdat = UID1;
         6'h0a:           rdat = UID2;
         6'h0b:           rdat = UID3;
         default:         rdat = 32'h0000_0000;
      endcase
   end
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= acc;
         wb_dat_o <= rdat;
      end
   end
endmodule
`default_nettype wire

/* core/code_flash_map.vh */
`ifndef CODE_FLASH_MAP_VH
`define CODE_FLASH_MAP_VH
// ==========================================
// register word offsets (byte address / 4)
`define CF_PE_CTRL      6'h00
`define CF_CACHE_EN     6'h01
`define CF_CACHE_INV    6'h02
`define CF_STARTUP_SEL  6'h03
`define CF_IRQ_STATUS   6'h04
`define CF_IRQ_MASK     6'h05
`define CF_PE_STATE     6'h06
`define CF_PE_ADDR      6'h07
`define CF_UID_BASE     6'h08
`define CF_CMD_AREA     6'h10
// ==========================================
// field positions
`define CF_DUAL_BIT     2
`define CF_GUARD_BIT    3
`define CF_VIOL_BIT     0
`define CF_DONE_BIT     1
// ==========================================
// values
`define CF_PE_ENABLED   2'b01
`define CF_CTRL_RST     4'h0
`define CF_BLK_GUARD0   6'h08
`define CF_BLK_GUARD1   6'h09
`define CF_BLK_GUARD2   6'h2e
`define CF_BLK_GUARD3   6'h2f
// ==========================================
// commands written to the command area
`define CF_CMD_PROG     8'he8
`define CF_CMD_ERASE    8'h20
`define CF_CMD_BLANK    8'h71
`define CF_CMD_SUSPEND  8'hb0
`define CF_CMD_RESUME   8'hd0
// ==========================================
// geometry and timing
`define CF_WAYS         8
`define CF_SETS         2
`define CF_PROG_WORDS   32
`define CF_MHZ_1CYC     50
`define CF_MHZ_2CYC     100
`endif

/* dv/code_flash_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// port checker for the code flash controller
module code_flash_monitor (
   // clock and reset
   input wire logic        clk_i,
   input wire logic        rst_i,
   // register bus
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   // read port
   input wire logic        rd_req_i,
   input wire logic        rd_ack_o,
   input wire logic        rd_err_o,
   input wire logic [31:0] rd_data_o,
   // array side
   input wire logic        fl_rd_o,
   input wire logic        fl_erase_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // a request taken while the port is idle
   sequence s_taken;
      rd_req_i && !rd_ack_o && !fl_rd_o;
   endsequence
   // one fetch cycle, then the answer
   sequence s_fetch;
      fl_rd_o ##1 (rd_ack_o && !fl_rd_o);
   endsequence
   property p_rd_taken;
      s_taken |=> (rd_ack_o || fl_rd_o);
   endproperty
   property p_rd_miss;
      $rose(fl_rd_o) |-> s_fetch;
   endproperty
   property p_rd_err;
      rd_err_o |-> rd_ack_o && (rd_data_o == 32'h0000_0000);
   endproperty
   property p_rd_hold;
      !rd_ack_o |-> $stable(rd_data_o);
   endproperty
   property p_wb_answer;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   property p_wb_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   property p_wb_idle;
      !wb_stb_i |=> !wb_ack_o;
   endproperty
   property p_erase_pulse;
      fl_erase_o |=> !fl_erase_o;
   endproperty
   a_rd_taken: assert property (p_rd_taken) else $error("read not answered in time");
   a_rd_miss: assert property (p_rd_miss) else $error("miss not answered after fetch");
   a_rd_err: assert property (p_rd_err) else $error("blocked read gave data");
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved between answers");
   a_wb_answer: assert property (p_wb_answer) else $error("bus request not acked");
   a_wb_pulse: assert property (p_wb_pulse) else $error("bus ack longer than one cycle");
   a_wb_idle: assert property (p_wb_idle) else $error("bus ack without request");
   a_erase_pulse: assert property (p_erase_pulse) else $error("erase start not a pulse");
endmodule
bind code_flash_ctrl code_flash_monitor i_mon (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .rd_req_i(rd_req_i),
   .rd_ack_o(rd_ack_o), .rd_err_o(rd_err_o), .rd_data_o(rd_data_o), .fl_rd_o(fl_rd_o),
   .fl_erase_o(fl_erase_o));
`default_nettype wire

/* dv/flash_array_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// array model: each word carries its own word address
module flash_array_model (
   // clock
   input wire logic         clk_i,
   // line fetch
   input wire logic         fl_rd_i,
   input wire logic [16:0]  raddr_i,
   output logic     [127:0] line_o
);
   logic [127:0] last_line = '0; // line shown by the last fetch
   // build one line from its address
   function automatic logic [127:0] line_of(input logic [16:0] a);
      return {13'h0000, a, 2'h3, 13'h0000, a, 2'h2, 13'h0000, a, 2'h1, 13'h0000, a, 2'h0};
   endfunction
   // remember the line so the idle bus can show its inverse
   always @(posedge clk_i) begin
      if (fl_rd_i) begin
         last_line <= line_of(raddr_i);
      end
   end
   // outside a fetch the bus holds no valid line
   assign line_o = fl_rd_i ? line_of(raddr_i) : ~last_line;
endmodule
`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "code_flash_map.vh"
// ==========================================
// self-checking bench
module testbench;
   // id words, arbitrary values
   localparam logic [31:0] U0 = 32'h0a0b_0c0d, U1 = 32'h1a1b_1c1d;
   localparam logic [31:0] U2 = 32'h2a2b_2c2d, U3 = 32'h3a3b_3c3d;
   logic        clk_i = 1'h0, rst_i = 1'h1;                  // clock and reset
   logic        wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0; // bus request
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd_data_o, fl_wdata_o;
   logic        wb_ack_o, rd_ack_o, rd_err_o, fl_rd_o, fl_wr_o, fl_erase_o, irq_o;
   logic        rd_req_i = 1'h0;                              // read port
   logic [20:0] rd_addr_i = 21'h00_0000;
   logic [16:0] fl_raddr_o;
   logic [18:0] fl_waddr_o;
   logic [127:0] fl_line_i;
   logic [5:0]  fl_eblk_o, last_blk = 6'h00;
   int          n_fail = 0, check_count = 0, cyc_n = 0, n_wr = 0;
   logic [31:0] q;
   always #25 clk_i = ~clk_i;
   code_flash_ctrl #(.PROG_CYCLES(4), .ERASE_CYCLES(8), .UID0(U0), .UID1(U1), .UID2(U2),
      .UID3(U3)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rd_req_i(rd_req_i), .rd_addr_i(rd_addr_i),
      .rd_ack_o(rd_ack_o), .rd_err_o(rd_err_o), .rd_data_o(rd_data_o), .fl_rd_o(fl_rd_o),
      .fl_raddr_o(fl_raddr_o), .fl_line_i(fl_line_i), .fl_wr_o(fl_wr_o),
      .fl_waddr_o(fl_waddr_o), .fl_wdata_o(fl_wdata_o), .fl_erase_o(fl_erase_o),
      .fl_eblk_o(fl_eblk_o), .irq_o(irq_o));
   flash_array_model i_arr (.clk_i(clk_i), .fl_rd_i(fl_rd_o), .raddr_i(fl_raddr_o),
      .line_o(fl_line_i));
   // count program writes, note erased block, cut a hang short
   always @(posedge clk_i) begin
      cyc_n <= cyc_n + 1;
      if (fl_wr_o === 1'h1) begin
         n_wr <= n_wr + 1;
         chk("program address", {13'h0000, fl_waddr_o}, 32'h0000_4000 + n_wr);
         chk("program data", fl_wdata_o, 32'h5a00_0000 + n_wr);
      end
      if (fl_erase_o === 1'h1) last_blk <= fl_eblk_o;
      if (cyc_n == 20000) begin
         n_fail++;
         print_verdict();
      end
   end
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one classic bus cycle, then one idle cycle
   task automatic wb(input logic we, input logic [5:0] idx, input logic [31:0] d);
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i <= we;
      wb_adr_i <= {idx, 2'h0};
      wb_dat_i <= d;
      do @(posedge clk_i); while (wb_ack_o !== 1'h1);
      q = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
      @(posedge clk_i);
   endtask
   task automatic rdchk(input string what, input logic [5:0] idx, input logic [31:0] exp);
      wb(1'h0, idx, 32'h0000_0000);
      chk(what, q, exp);
   endtask
   // word the array holds at a byte address
   function automatic logic [31:0] ew(input logic [20:0] a);
      return {13'h0000, a[20:2]};
   endfunction
   // processor read: data, edges from take to answer, error flag
   task automatic rd(input logic [20:0] a, input logic [31:0] exp, input int ne, input logic e);
      int n;
      n = 0;
      rd_req_i <= 1'h1;
      rd_addr_i <= a;
      do begin
         @(posedge clk_i);
         n++;
      end while (rd_ack_o !== 1'h1);
      chk("read data", rd_data_o, exp);
      chk("read cycles", n, ne);
      chk("read error", {31'h0, rd_err_o}, {31'h0, e});
      rd_req_i <= 1'h0;
      @(posedge clk_i);
   endtask
   task automatic wait_done;
      int i;
      for (i = 0; i < 60 && q[1] !== 1'h1; i++) wb(1'h0, `CF_IRQ_STATUS, 32'h0000_0000);
      chk("done flag", {31'h0, q[1]}, 32'h0000_0001);
      wb(1'h1, `CF_IRQ_STATUS, 32'h0000_0003);
   endtask
   task automatic t_regs;
      rdchk("pe ctrl", `CF_PE_CTRL, 32'h0000_0000);
      rdchk("cache enable", `CF_CACHE_EN, 32'h0000_0000);
      rdchk("invalidate", `CF_CACHE_INV, 32'h0000_0000);
      rdchk("id 0", `CF_UID_BASE, U0);
      rdchk("id 1", `CF_UID_BASE + 6'h01, U1);
      rdchk("id 2", `CF_UID_BASE + 6'h02, U2);
      rdchk("id 3", `CF_UID_BASE + 6'h03, U3);
      rdchk("unmapped", 6'h3f, 32'h0000_0000);
      $display("test regs done");
   endtask
   task automatic t_cache;
      int k;
      rd(21'h00_0100, ew(21'h00_0100), 3, 1'h0);
      rd(21'h00_0100, ew(21'h00_0100), 3, 1'h0);
      wb(1'h1, `CF_CACHE_EN, 32'h0000_0001);
      for (k = 0; k < 8; k++) rd(21'h1000 + k * 32, ew(21'h1000 + k * 32), 3, 1'h0);
      for (k = 0; k < 8; k++) rd(21'h1000 + k * 32, ew(21'h1000 + k * 32), 2, 1'h0);
      rd(21'h00_1000, ew(21'h00_1000), 2, 1'h0);
      rd(21'h00_1100, ew(21'h00_1100), 3, 1'h0);
      rd(21'h00_1004, ew(21'h00_1004), 2, 1'h0);
      rd(21'h00_1020, ew(21'h00_1020), 3, 1'h0);
      rd(21'h00_1010, ew(21'h00_1010), 3, 1'h0);
      wb(1'h1, `CF_CACHE_INV, 32'h0000_0001);
      rd(21'h00_1000, ew(21'h00_1000), 3, 1'h0);
      wb(1'h1, `CF_CACHE_EN, 32'h0000_0000);
      $display("test cache done");
   endtask
   task automatic t_guard;
      wb(1'h1, `CF_IRQ_MASK, 32'h0000_0001);
      wb(1'h1, `CF_PE_CTRL, 32'h0000_0008);
      rd(21'h04_0000, 32'h0000_0000, 2, 1'h1);
      chk("irq raised", {31'h0, irq_o}, 32'h0000_0001);
      wb(1'h1, `CF_IRQ_STATUS, 32'h0000_0001);
      chk("irq cleared", {31'h0, irq_o}, 32'h0000_0000);
      wb(1'h1, `CF_IRQ_MASK, 32'h0000_0000);
      rd(21'h04_8000, 32'h0000_0000, 2, 1'h1);
      chk("irq masked", {31'h0, irq_o}, 32'h0000_0000);
      rdchk("violation", `CF_IRQ_STATUS, 32'h0000_0001);
      wb(1'h1, `CF_IRQ_STATUS, 32'h0000_0001);
      rd(21'h17_0000, ew(21'h17_0000), 3, 1'h0);
      wb(1'h1, `CF_PE_CTRL, 32'h0000_000c);
      rd(21'h17_0000, 32'h0000_0000, 2, 1'h1);
      rd(21'h17_8000, 32'h0000_0000, 2, 1'h1);
      wb(1'h1, `CF_PE_CTRL, 32'h0000_0000);
      wb(1'h1, `CF_IRQ_STATUS, 32'h0000_0001);
      wb(1'h1, `CF_STARTUP_SEL, 32'h0000_0001);
      rd(21'h00_0020, ew(21'h00_8020), 3, 1'h0);
      wb(1'h1, `CF_STARTUP_SEL, 32'h0000_0000);
      $display("test guard done");
   endtask
   task automatic t_pe;
      int i;
      logic [1:0] pat [3] = '{2'h0, 2'h2, 2'h3};
      for (i = 0; i < 3; i++) begin
         wb(1'h1, `CF_PE_CTRL, {30'h0, pat[i]});
         wb(1'h1, `CF_CMD_AREA, `CF_CMD_ERASE);
         rdchk("refused", `CF_IRQ_STATUS, 32'h0000_0001);
         wb(1'h1, `CF_IRQ_STATUS, 32'h0000_0001);
      end
      wb(1'h1, `CF_PE_CTRL, 32'h0000_0001);
      wb(1'h1, `CF_CMD_AREA, 32'h0000_0055);
      rdchk("unknown command", `CF_IRQ_STATUS, 32'h0000_0001);
      wb(1'h1, `CF_IRQ_STATUS, 32'h0000_0001);
      wb(1'h1, `CF_PE_ADDR, 32'h0001_0000);
      wb(1'h1, `CF_CMD_AREA, `CF_CMD_ERASE);
      wb(1'h1, `CF_CMD_AREA, `CF_CMD_SUSPEND);
      rdchk("suspended", `CF_PE_STATE, 32'h0000_0006);
      rd(21'h00_0200, ew(21'h00_0200), 3, 1'h0);
      repeat (20) @(posedge clk_i);
      rdchk("frozen", `CF_IRQ_STATUS, 32'h0000_0000);
      wb(1'h1, `CF_CMD_AREA, `CF_CMD_RESUME);
      wait_done();
      chk("erase block", {26'h0, last_blk}, 32'h0000_0002);
      rd(21'h01_0000, 32'hffff_ffff, 2, 1'h0);
      wb(1'h1, `CF_CMD_AREA, `CF_CMD_BLANK);
      rdchk("blank", `CF_PE_STATE, 32'h0000_0008);
      wait_done();
      wb(1'h1, `CF_CMD_AREA, `CF_CMD_PROG);
      for (i = 0; i < 32; i++) wb(1'h1, `CF_CMD_AREA, 32'h5a00_0000 + i);
      wait_done();
      chk("program writes", n_wr, 32'h0000_0020);
      rd(21'h01_0000, ew(21'h01_0000), 3, 1'h0);
      $display("test program erase done");
   endtask
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'h0;
      @(posedge clk_i);
      t_regs();
      t_cache();
      t_guard();
      t_pe();
      print_verdict();
   end
endmodule
`default_nettype wire
